// *** hdl/quad_decoder_pkg.sv ***
// Behaviour
// - Signed 16-bit step counter per axis
// - One shared 8-bit edge tally
// - Sample channels on system clock, programmable rate
// - Leading channel decides direction
// - Quadrature mode or plain edge mode
// - Simultaneous edges on axis: no count in quadrature mode, one in edge mode
// - Filter rejects pulses under three samples
// - Disabled axis clears its counter
// - Tally counts edges in every mode
// - Simultaneous edges raise tally by one
// - Divider value plus one sets clocks per sample period
// - Low-power clock bypasses the divider
// - Threshold raises interrupt, tally keeps counting
// - Per-axis pin selection registers
// - Per-axis count mode in control two
// - Writes clear interrupt and clear tally
// - Counters readable over APB
// - Works only while clock enable set
// - Threshold interrupt doubles as the wake-up request
package quad_decoder_pkg;
    localparam int AXES = 3;
    localparam int PIN_SEL_W = 4;
    localparam int DIV_W = 10;
    localparam logic [11:0] OFS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_X_SELECT = 12'h004;
    localparam logic [11:0] OFS_Y_SELECT = 12'h008;
    localparam logic [11:0] OFS_Z_SELECT = 12'h00C;
    localparam logic [11:0] OFS_X_COUNT = 12'h010;
    localparam logic [11:0] OFS_Y_COUNT = 12'h014;
    localparam logic [11:0] OFS_Z_COUNT = 12'h018;
    localparam logic [11:0] OFS_DIVIDER = 12'h01C;
    localparam logic [11:0] OFS_TALLY = 12'h020;
    localparam logic [11:0] OFS_CONTROL_TWO = 12'h024;
    // Control register fields
    localparam int CTL_THRES_LSB = 0;
    localparam int CTL_PENDING_BIT = 8;
    localparam int CTL_CLEAR_BIT = 9;
    localparam int CTL_ENABLE_BIT = 10;
    localparam int CTL_LOW_POWER_BIT = 11;
    // Control two: bits 0..2 axis enable, 3..5 edge mode
    localparam int CT2_EN_LSB = 0;
    localparam int CT2_MODE_LSB = 3;
    localparam logic [7:0] THRES_RESET = 8'h01;
    localparam logic [DIV_W-1:0] DIV_RESET = 10'h000;
    localparam int FILTER_LEN = 3;
endpackage

// *** hdl/channel_filter.sv ***
// Majority-free spike filter: output follows only a stable run
module channel_filter
    import quad_decoder_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sample_en,
    input wire logic raw_in,
    output logic filt_out,
    output logic edge_seen
);
    logic [FILTER_LEN-1:0] hist_r, hist_nxt;
    logic filt_r, filt_nxt;
    logic edge_r, edge_nxt;

    // Change only after three equal samples
    always_comb begin
        hist_nxt = hist_r;
        filt_nxt = filt_r;
        edge_nxt = 1'b0;
        if (sample_en) begin
            hist_nxt = {hist_r[FILTER_LEN-2:0], raw_in};
            if (&hist_nxt && !filt_r) begin
                filt_nxt = 1'b1;
                edge_nxt = 1'b1;
            end else if (~|hist_nxt && filt_r) begin
                filt_nxt = 1'b0;
                edge_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_r <= '0;
            filt_r <= 1'b0;
            edge_r <= 1'b0;
        end else begin
            hist_r <= hist_nxt;
            filt_r <= filt_nxt;
            edge_r <= edge_nxt;
        end
    end

    assign filt_out = filt_r;
    assign edge_seen = edge_r;
endmodule

// *** hdl/axis_counter.sv ***
// One axis: Gray decode or edge count into a wrapping counter
module axis_counter
    import quad_decoder_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic edge_mode,
    input wire logic phase_a,
    input wire logic phase_b,
    input wire logic step_a,
    input wire logic step_b,
    output logic [15:0] count
);
    logic [1:0] prev_r, prev_nxt;
    logic [15:0] count_r, count_nxt;
    logic [1:0] cur;

    assign cur = {phase_a, phase_b};

    always_comb begin
        prev_nxt = prev_r;
        count_nxt = count_r;
        if (!enable) begin
            count_nxt = 16'h0000;
            prev_nxt = cur;
        end else if (step_a || step_b) begin
            prev_nxt = cur;
            if (edge_mode) begin
                count_nxt = count_r + 16'h0001;
            end else if (step_a != step_b) begin
                // A leading gives up, B leading gives down
                if ((prev_r[1] ^ prev_r[0]) == step_b)
                    count_nxt = count_r + 16'h0001;
                else
                    count_nxt = count_r - 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= 2'b00;
            count_r <= 16'h0000;
        end else begin
            prev_r <= prev_nxt;
            count_r <= count_nxt;
        end
    end

    assign count = count_r;

    // Count checks; a double step in quadrature mode must leave the count alone
    a_double_step: assert property (
        @(posedge pclk) disable iff (!presetn)
        enable && !edge_mode && step_a && step_b |=>
        count_r == $past(count_r))
        else $error("double transition changed count");
    a_disable_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        !enable |=> count_r == 16'h0000)
        else $error("disabled axis not cleared");
    a_edge_one: assert property (
        @(posedge pclk) disable iff (!presetn)
        enable && edge_mode && (step_a || step_b) |=>
        count_r == $past(count_r) + 16'h0001)
        else $error("edge mode step not one");
endmodule

// *** hdl/quad_decoder.sv ***
// Three-axis quadrature decoder, APB slave
//
// The APB interface to the registers and the register addresses are this design's own decisions.
module quad_decoder
    import quad_decoder_pkg::*;
#(
    parameter int PINS = 12
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PINS-1:0] gpio_in,
    output logic edge_irq,
    output logic motion_wake
);
    // Software state
    logic [7:0] thres_r, thres_nxt;
    logic pending_r, pending_nxt;
    logic enable_r, enable_nxt;
    logic low_power_clock_r, low_power_clock_nxt;
    logic [2:0] axis_en_r, axis_en_nxt;
    logic [2:0] mode_r, mode_nxt;
    logic [DIV_W-1:0] div_r, div_nxt;
    logic [2*PIN_SEL_W-1:0] sel_r [AXES];
    logic [2*PIN_SEL_W-1:0] sel_nxt [AXES];
    logic [7:0] tally_r, tally_nxt;
    logic [DIV_W-1:0] dcnt_r, dcnt_nxt;
    logic [PINS-1:0] sync1_r, sync2_r;
    logic [31:0] prdata_r, prdata_nxt;
    logic sample_en;
    logic [2*AXES-1:0] filt, step;
    logic [15:0] cnt [AXES];
    logic wr, rd, any_edge, hit;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_r;

    // Two-stage synchroniser on pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= gpio_in;
            sync2_r <= sync1_r;
        end
    end

    // Sampling divider; bypassed on low-power clock
    always_comb begin
        dcnt_nxt = dcnt_r;
        sample_en = 1'b0;
        if (!enable_r) begin
            dcnt_nxt = '0;
        end else if (low_power_clock_r || div_r == '0) begin
            sample_en = 1'b1;
            dcnt_nxt = '0;
        end else if (dcnt_r >= div_r) begin
            sample_en = 1'b1;
            dcnt_nxt = '0;
        end else begin
            dcnt_nxt = dcnt_r + 1'b1;
        end
    end

    // Per-axis pin select, filter and counter
    genvar g;
    generate
        for (g = 0; g < AXES; g++) begin : g_axis
            logic [PIN_SEL_W-1:0] sa, sb;
            logic pa, pb;
            assign sa = sel_r[g][PIN_SEL_W-1:0];
            assign sb = sel_r[g][2*PIN_SEL_W-1:PIN_SEL_W];
            // Out-of-range selection reads low
            assign pa = (sa < PINS) ? sync2_r[sa] : 1'b0;
            assign pb = (sb < PINS) ? sync2_r[sb] : 1'b0;
            channel_filter u_fa (
                .pclk(pclk), .presetn(presetn), .sample_en(sample_en),
                .raw_in(pa), .filt_out(filt[2*g]), .edge_seen(step[2*g])
            );
            channel_filter u_fb (
                .pclk(pclk), .presetn(presetn), .sample_en(sample_en),
                .raw_in(pb), .filt_out(filt[2*g+1]),
                .edge_seen(step[2*g+1])
            );
            axis_counter u_cnt (
                .pclk(pclk), .presetn(presetn),
                .enable(axis_en_r[g] && enable_r),
                .edge_mode(mode_r[g]),
                .phase_a(filt[2*g]), .phase_b(filt[2*g+1]),
                .step_a(step[2*g]), .step_b(step[2*g+1]),
                .count(cnt[g])
            );
        end
    endgenerate

    // Any edge on an enabled axis, in any mode
    always_comb begin
        any_edge = 1'b0;
        for (int i = 0; i < AXES; i++)
            if (axis_en_r[i] && (step[2*i] || step[2*i+1]))
                any_edge = 1'b1;
    end

    assign hit = enable_r && any_edge && (tally_r + 8'h01 == thres_r);

    // Register writes, tally and pending flag
    always_comb begin
        thres_nxt = thres_r;
        pending_nxt = pending_r;
        enable_nxt = enable_r;
        low_power_clock_nxt = low_power_clock_r;
        axis_en_nxt = axis_en_r;
        mode_nxt = mode_r;
        div_nxt = div_r;
        tally_nxt = tally_r;
        for (int i = 0; i < AXES; i++)
            sel_nxt[i] = sel_r[i];
        if (enable_r && any_edge)
            tally_nxt = tally_r + 8'h01;
        if (wr) begin
            unique case (paddr)
                OFS_CONTROL: begin
                    thres_nxt = pwdata[CTL_THRES_LSB +: 8];
                    enable_nxt = pwdata[CTL_ENABLE_BIT];
                    low_power_clock_nxt = pwdata[CTL_LOW_POWER_BIT];
                    if (pwdata[CTL_PENDING_BIT])
                        pending_nxt = 1'b0;
                    if (pwdata[CTL_CLEAR_BIT])
                        tally_nxt = 8'h00;
                end
                OFS_X_SELECT: sel_nxt[0] = pwdata[2*PIN_SEL_W-1:0];
                OFS_Y_SELECT: sel_nxt[1] = pwdata[2*PIN_SEL_W-1:0];
                OFS_Z_SELECT: sel_nxt[2] = pwdata[2*PIN_SEL_W-1:0];
                OFS_DIVIDER: div_nxt = pwdata[DIV_W-1:0];
                OFS_CONTROL_TWO: begin
                    axis_en_nxt = pwdata[CT2_EN_LSB +: 3];
                    mode_nxt = pwdata[CT2_MODE_LSB +: 3];
                end
                default: ;
            endcase
        end
        // Set beats a same-cycle clear
        if (hit)
            pending_nxt = 1'b1;
    end

    // Read mux, captured in setup phase
    always_comb begin
        prdata_nxt = prdata_r;
        if (rd) begin
            unique case (paddr)
                OFS_CONTROL: prdata_nxt = {20'h00000,
                    low_power_clock_r, enable_r, 1'b0, pending_r, thres_r};
                OFS_X_SELECT: prdata_nxt = {24'h000000, sel_r[0]};
                OFS_Y_SELECT: prdata_nxt = {24'h000000, sel_r[1]};
                OFS_Z_SELECT: prdata_nxt = {24'h000000, sel_r[2]};
                OFS_X_COUNT: prdata_nxt = {16'h0000, cnt[0]};
                OFS_Y_COUNT: prdata_nxt = {16'h0000, cnt[1]};
                OFS_Z_COUNT: prdata_nxt = {16'h0000, cnt[2]};
                OFS_DIVIDER: prdata_nxt = {22'h000000, div_r};
                OFS_TALLY: prdata_nxt = {24'h000000, tally_r};
                OFS_CONTROL_TWO: prdata_nxt = {26'h0000000, mode_r,
                    axis_en_r};
                default: prdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thres_r <= THRES_RESET;
            pending_r <= 1'b0;
            enable_r <= 1'b0;
            low_power_clock_r <= 1'b0;
            axis_en_r <= 3'h0;
            mode_r <= 3'h0;
            div_r <= DIV_RESET;
            tally_r <= 8'h00;
            dcnt_r <= '0;
            prdata_r <= 32'h00000000;
            for (int i = 0; i < AXES; i++)
                sel_r[i] <= '0;
        end else begin
            thres_r <= thres_nxt;
            pending_r <= pending_nxt;
            enable_r <= enable_nxt;
            low_power_clock_r <= low_power_clock_nxt;
            axis_en_r <= axis_en_nxt;
            mode_r <= mode_nxt;
            div_r <= div_nxt;
            tally_r <= tally_nxt;
            dcnt_r <= dcnt_nxt;
            prdata_r <= prdata_nxt;
            for (int i = 0; i < AXES; i++)
                sel_r[i] <= sel_nxt[i];
        end
    end

    assign edge_irq = pending_r;
    assign motion_wake = pending_r;

    // Tally, interrupt and sampling checks
    a_tally_step: assert property (
        @(posedge pclk) disable iff (!presetn)
        enable_r && any_edge && !wr |=> tally_r == $past(tally_r) + 8'h01)
        else $error("tally did not step by one");
    a_irq_raise: assert property (
        @(posedge pclk) disable iff (!presetn)
        hit |=> pending_r)
        else $error("threshold did not raise interrupt");
    a_no_sample_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        !enable_r |-> !sample_en)
        else $error("sampling while disabled");
    a_bypass_div: assert property (
        @(posedge pclk) disable iff (!presetn)
        enable_r && low_power_clock_r |-> sample_en)
        else $error("divider not bypassed");
    a_tally_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == OFS_CONTROL && pwdata[CTL_CLEAR_BIT] |=>
        tally_r == 8'h00)
        else $error("tally not cleared");
endmodule

// *** bench/quad_encoder_model.sv ***
// One axis of a motion device: two channels in Gray order
module quad_encoder_model #(
    parameter int HOLD = 8
)
(
    input wire logic pclk,
    output logic phase_a,
    output logic phase_b
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] pos;

    // Both channels rest low, as a device at power-up
    initial begin
        pos = 2'h0;
        phase_a = 1'b0;
        phase_b = 1'b0;
    end

    // One Gray transition per step, A leading when forward
    task automatic move(input int n, input bit fwd);
        for (int i = 0; i < n; i++) begin
            pos = fwd ? pos + 2'h1 : pos - 2'h1;
            @(posedge pclk);
            phase_a <= pos[1] ^ pos[0];
            phase_b <= pos[1];
            // Held well past the filter length
            repeat (HOLD) @(posedge pclk);
        end
    endtask

    // Both channels flip together: an illegal double step
    task automatic jump();
        pos = pos + 2'h2;
        @(posedge pclk);
        phase_a <= pos[1] ^ pos[0];
        phase_b <= pos[1];
        repeat (HOLD) @(posedge pclk);
    endtask

    // Short pulse on channel A, only when a scenario asks
    task automatic glitch(input int len);
        @(posedge pclk);
        phase_a <= ~phase_a;
        repeat (len) @(posedge pclk);
        phase_a <= ~phase_a;
        repeat (HOLD) @(posedge pclk);
    endtask
endmodule

// *** bench/three_axis_quadrature_decoder_tb.sv ***
`define CHK(nm, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("mismatch %s expected %h seen %h", nm, exp, got); \
        end \
    end

module three_axis_quadrature_decoder_tb
    import quad_decoder_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [5:0] gpio_hi;
    logic edge_irq, motion_wake, xa, xb, ya, yb, za, zb;
    logic [75:0] note;
    logic [75:0] notes[$];
    int mismatches, check_count, cycles, seed, ny;

    quad_decoder #(.PINS(12)) i_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .gpio_in({gpio_hi, zb, za, yb, ya, xb, xa}),
        .edge_irq(edge_irq),
        .motion_wake(motion_wake)
    );
    quad_encoder_model i_enc_x (.pclk(pclk), .phase_a(xa), .phase_b(xb));
    quad_encoder_model i_enc_y (.pclk(pclk), .phase_a(ya), .phase_b(yb));
    quad_encoder_model i_enc_z (.pclk(pclk), .phase_a(za), .phase_b(zb));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Setup, then access held until pready; idle edge after release
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Note the masked expectation, then read
    task automatic rd(input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        notes.push_back({a, m, e});
        apb(1'b0, a, 32'h0);
    endtask

    // Oldest note against each completed read
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0
            && pready === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            `CHK($sformatf("read %h", note[75:64]), note[31:0],
                 prdata & note[63:32])
            `CHK("pslverr", 1'b0, pslverr)
        end
    end

    // Hang guard, far above the expected run length
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 8000) begin
            mismatches++;
            wrap_up();
        end
    end

    initial begin
        seed = 32'h736B;
        mismatches = 0;
        check_count = 0;
        cycles = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        // Unselected pins carry random levels
        gpio_hi = 6'($random(seed));
        ny = 1 + ($random(seed) & 3);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFS_CONTROL, 32'hFFFF_FFFF, 32'h0000_0001);
        rd(OFS_TALLY, 32'hFFFF_FFFF, 32'h0);
        rd(12'h030, 32'hFFFF_FFFF, 32'h0);
        apb(1'b1, OFS_X_SELECT, 32'h10);
        apb(1'b1, OFS_Y_SELECT, 32'h32);
        apb(1'b1, OFS_Z_SELECT, 32'h54);
        apb(1'b1, OFS_CONTROL, 32'h0000_0406);
        apb(1'b1, OFS_CONTROL_TWO, 32'h0000_0027);
        i_enc_x.move(4, 1'b1);
        repeat (12) @(posedge pclk);
        `CHK("irq low", 1'b0, edge_irq)
        i_enc_y.move(ny, 1'b0);
        i_enc_z.move(2, 1'b1);
        repeat (12) @(posedge pclk);
        rd(OFS_X_COUNT, 32'hFFFF, 32'h4);
        rd(OFS_Y_COUNT, 32'hFFFF, {16'h0, 16'(-ny)});
        rd(OFS_Z_COUNT, 32'hFFFF, 32'h2);
        rd(OFS_TALLY, 32'hFF, 32'(6 + ny));
        `CHK("irq", 1'b1, edge_irq)
        `CHK("wake", 1'b1, motion_wake)
        // Tally first, so a still-high tally cannot re-raise the flag
        apb(1'b1, OFS_CONTROL, 32'h0000_0606);
        rd(OFS_TALLY, 32'hFF, 32'h0);
        apb(1'b1, OFS_CONTROL, 32'h0000_0506);
        `CHK("irq cleared", 1'b0, edge_irq)
        // Swapped pins turn forward motion into a count down
        apb(1'b1, OFS_X_SELECT, 32'h01);
        i_enc_x.move(2, 1'b1);
        repeat (12) @(posedge pclk);
        rd(OFS_X_COUNT, 32'hFFFF, 32'h0002);
        // Six clocks at a period of four give at most two samples
        apb(1'b1, OFS_DIVIDER, 32'h3);
        i_enc_x.glitch(6);
        repeat (30) @(posedge pclk);
        rd(OFS_TALLY, 32'hFF, 32'h2);
        // Low-power flag: every clock samples, so the pulse passes
        apb(1'b1, OFS_CONTROL, 32'h0000_0C06);
        i_enc_x.glitch(6);
        repeat (12) @(posedge pclk);
        rd(OFS_TALLY, 32'hFF, 32'h4);
        // Both channels at once: no step, a single tally count
        i_enc_x.jump();
        repeat (12) @(posedge pclk);
        rd(OFS_TALLY, 32'hFF, 32'h5);
        rd(OFS_X_COUNT, 32'hFFFF, 32'h0002);
        apb(1'b1, OFS_CONTROL_TWO, 32'h0000_0026);
        rd(OFS_X_COUNT, 32'hFFFF, 32'h0);
        wrap_up();
    end
endmodule
